// ===== ofr_consts.vh
/*
  Constants of the off-core response event filter: register byte offsets,
  field positions of the two 64-bit filter registers, reset values and
  AXI4-Lite answer codes.
  Assumes inclusion by bare name from the filter's design files.
*/
`ifndef OFR_CONSTS_VH
`define OFR_CONSTS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFR_ADDR_F0_LO 8'h00
`define OFR_ADDR_F0_HI 8'h04
`define OFR_ADDR_F1_LO 8'h08
`define OFR_ADDR_F1_HI 8'h0c
`define OFR_ADDR_STAT 8'h10
`define OFR_ADDR_MASK 8'h14
`define OFR_ADDR_CTRL 8'h18
`define OFR_ADDR_CNT0 8'h1c
`define OFR_ADDR_CNT1 8'h20
`define OFR_ADDR_CFG 8'h24

// ---------------------------------------------------------------
// filter field layout
// ---------------------------------------------------------------
`define OFR_REQ_LO_MASK 16'h9c7f
`define OFR_REQ_DEMAND_RD 6'h00
`define OFR_REQ_L1_SW_PF 6'h0a
`define OFR_REQ_HI_LSB 44
`define OFR_REQ_HI_MSB 49
`define OFR_RSP_ANY 16
`define OFR_SUP_LSB 17
`define OFR_SUP_MSB 30
`define OFR_SNP_LSB 31
`define OFR_SNP_MSB 37
`define OFR_LATENCY 63
`define OFR_HI_LATENCY 31

// ---------------------------------------------------------------
// status bits, reset values, answers
// ---------------------------------------------------------------
`define OFR_ST_FAULT 0
`define OFR_ST_BAD0 1
`define OFR_ST_BAD1 2
`define OFR_ST_WRAP0 3
`define OFR_ST_WRAP1 4
`define OFR_ST_PAIR 5
`define OFR_ST_W 6
`define OFR_FILT_RST 64'h0000000000000000
`define OFR_CTRL_RST 2'h0
`define OFR_RESP_OK 2'h0
`define OFR_RESP_SLVERR 2'h2
`define OFR_RESP_DECERR 2'h3

`endif

// ===== ofr_match.v
/*
  One filter's match logic: checks the programming and decides the
  counter increment for the presented transaction.
  Assumes the transaction fields are stable in the cycle txnValid is high.
*/
`include "ofr_consts.vh"

module ofr_match #(
  parameter CW = 8
) (
  input wire [63:0] filt, // filter register value
  input wire txnValid, // transaction seen this cycle
  input wire [5:0] txnReqIdx, // request kind bit position
  input wire txnIsPrefetch, // issued by L1 or software prefetch
  input wire txnIsWrite, // write class transaction
  input wire [13:0] txnSupplier, // supplier bits 30:17
  input wire txnAnyRsp, // transaction carries an outcome at all
  input wire [6:0] txnProbe, // probe bits 37:31
  input wire [CW-1:0] outstandingCnt, // requests in flight this cycle
  output wire cfgOk, // programming complete and valid
  output wire latMode, // latency accumulation selected
  output reg [CW-1:0] incr // amount to add this cycle
);
  wire [5:0] kind;
  wire reqOk;
  wire rdOk;
  wire wrOk;
  wire reqHit;
  wire supHit;
  wire snpHit;
  wire rspHit;

  assign kind = (txnReqIdx == `OFR_REQ_DEMAND_RD && txnIsPrefetch) ?
                `OFR_REQ_L1_SW_PF : txnReqIdx;
  assign reqOk = |(filt[15:0] & `OFR_REQ_LO_MASK) |
                 |filt[`OFR_REQ_HI_MSB:`OFR_REQ_HI_LSB];
  assign latMode = filt[`OFR_LATENCY];
  assign rdOk = filt[`OFR_RSP_ANY] |
                (|filt[`OFR_SUP_MSB:`OFR_SUP_LSB] & |filt[`OFR_SNP_MSB:`OFR_SNP_LSB]) |
                latMode;
  assign wrOk = filt[`OFR_RSP_ANY] | |filt[`OFR_SUP_MSB:`OFR_SUP_LSB] | latMode;
  assign cfgOk = reqOk & rdOk & wrOk;
  assign reqHit = (kind <= 6'd49) && filt[kind];
  assign supHit = |(filt[`OFR_SUP_MSB:`OFR_SUP_LSB] & txnSupplier);
  assign snpHit = |(filt[`OFR_SNP_MSB:`OFR_SNP_LSB] & txnProbe);
  assign rspHit = filt[`OFR_RSP_ANY] ? txnAnyRsp :
                  (txnIsWrite ? supHit : (supHit & snpHit));

  always @* begin
    incr = {CW{1'b0}};
    if (latMode) begin
      incr = outstandingCnt;
    end else if (txnValid && reqHit && rspHit) begin
      incr = {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule // ofr_match

// ===== ofr_filter_top.v
/*
  Off-core response event filter: two 64-bit filter registers, their
  counters, a sticky status with mask and interrupt, all behind an
  AXI4-Lite slave.
  Assumes transaction inputs come from logic on clk, and the master keeps
  at most one write and one read under way.
*/
`include "ofr_consts.vh"

module ofr_filter_top #(
  parameter CW = 8
) (
  input wire clk, // core clock
  input wire reset, // async reset, active high
  input wire ce, // clock enable, freezes state when low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output wire [1:0] s_axi_bresp, // write response
  output wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output wire [31:0] s_axi_rdata, // read data
  output wire [1:0] s_axi_rresp, // read response
  output wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire txnValid, // off-core transaction this cycle
  input wire [5:0] txnReqIdx, // request kind bit position
  input wire txnIsPrefetch, // prefetch-issued request
  input wire txnIsWrite, // write class transaction
  input wire [13:0] txnSupplier, // supplier bits
  input wire txnAnyRsp, // transaction has an outcome
  input wire [6:0] txnProbe, // probe bits
  input wire [CW-1:0] outstandingCnt, // requests in flight
  output wire [CW-1:0] countInc0, // increment for first counter
  output wire [CW-1:0] countInc1, // increment for second counter
  output wire protectionFault, // illegal write pulse
  output wire irq // level interrupt
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [63:0] filt0_q;
  reg [63:0] filt1_q;
  reg [`OFR_ST_W-1:0] status_q;
  reg [`OFR_ST_W-1:0] mask_q;
  reg [1:0] ctrl_q;
  reg [31:0] cnt0_q;
  reg [31:0] cnt1_q;
  reg [CW-1:0] inc0_q;
  reg [CW-1:0] inc1_q;
  reg fault_q;
  reg awHeld_q;
  reg wHeld_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg bValid_q;
  reg [1:0] bResp_q;
  reg rValid_q;
  reg [31:0] rData_q;
  reg [1:0] rResp_q;

  wire cfgOk0;
  wire cfgOk1;
  wire lat0;
  wire lat1;
  wire [CW-1:0] inc0;
  wire [CW-1:0] inc1;
  wire doWrite;
  wire badHi1;
  wire mapped;
  wire [`OFR_ST_W-1:0] stSet;
  wire [`OFR_ST_W-1:0] stClr;
  wire [32:0] sum0;
  wire [32:0] sum1;
  wire latBad;
  wire pairBad;
  wire [31:0] maskWr;
  wire [31:0] ctrlWr;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function known;
    input [7:0] a;
    begin
      known = (a == `OFR_ADDR_F0_LO) || (a == `OFR_ADDR_F0_HI) ||
              (a == `OFR_ADDR_F1_LO) || (a == `OFR_ADDR_F1_HI) ||
              (a == `OFR_ADDR_STAT) || (a == `OFR_ADDR_MASK) ||
              (a == `OFR_ADDR_CTRL) || (a == `OFR_ADDR_CNT0) ||
              (a == `OFR_ADDR_CNT1) || (a == `OFR_ADDR_CFG);
    end
  endfunction

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  // address and data are caught separately so either may come first
  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign mapped = known(awAddr_q);
  // a set latency bit in the second filter is refused whole
  assign badHi1 = (awAddr_q == `OFR_ADDR_F1_HI) && wStrb_q[3] &&
                  wData_q[`OFR_HI_LATENCY];
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= `OFR_RESP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        if (!mapped) begin
          bResp_q <= `OFR_RESP_DECERR;
        end else if (badHi1) begin
          bResp_q <= `OFR_RESP_SLVERR;
        end else begin
          bResp_q <= `OFR_RESP_OK;
        end
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // filter and control registers
  // ---------------------------------------------------------------
  // merged word kept whole so the register takes its own width on purpose
  assign maskWr = merge({{(32-`OFR_ST_W){1'b0}}, mask_q}, wData_q, wStrb_q);
  assign ctrlWr = merge({30'h0, ctrl_q}, wData_q, wStrb_q);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      filt0_q <= `OFR_FILT_RST;
      filt1_q <= `OFR_FILT_RST;
      mask_q <= {`OFR_ST_W{1'b0}};
      ctrl_q <= `OFR_CTRL_RST;
      fault_q <= 1'b0;
    end else if (ce) begin
      fault_q <= doWrite && badHi1;
      if (doWrite && !badHi1) begin
        case (awAddr_q)
          `OFR_ADDR_F0_LO: filt0_q[31:0] <= merge(filt0_q[31:0], wData_q, wStrb_q);
          `OFR_ADDR_F0_HI: filt0_q[63:32] <= merge(filt0_q[63:32], wData_q, wStrb_q);
          `OFR_ADDR_F1_LO: filt1_q[31:0] <= merge(filt1_q[31:0], wData_q, wStrb_q);
          `OFR_ADDR_F1_HI: filt1_q[63:32] <= merge(filt1_q[63:32], wData_q, wStrb_q);
          `OFR_ADDR_MASK: mask_q <= maskWr[`OFR_ST_W-1:0];
          `OFR_ADDR_CTRL: ctrl_q <= ctrlWr[1:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // match logic
  // ---------------------------------------------------------------
  ofr_match #(.CW(CW)) uMatch0 (
    .filt(filt0_q),
    .txnValid(txnValid),
    .txnReqIdx(txnReqIdx),
    .txnIsPrefetch(txnIsPrefetch),
    .txnIsWrite(txnIsWrite),
    .txnSupplier(txnSupplier),
    .txnAnyRsp(txnAnyRsp),
    .txnProbe(txnProbe),
    .outstandingCnt(outstandingCnt),
    .cfgOk(cfgOk0),
    .latMode(lat0),
    .incr(inc0)
  );

  ofr_match #(.CW(CW)) uMatch1 (
    .filt(filt1_q),
    .txnValid(txnValid),
    .txnReqIdx(txnReqIdx),
    .txnIsPrefetch(txnIsPrefetch),
    .txnIsWrite(txnIsWrite),
    .txnSupplier(txnSupplier),
    .txnAnyRsp(txnAnyRsp),
    .txnProbe(txnProbe),
    .outstandingCnt(outstandingCnt),
    .cfgOk(cfgOk1),
    .latMode(lat1),
    .incr(inc1)
  );

  // latency bit must stand alone among outcome bits
  assign latBad = lat0 && (|filt0_q[`OFR_SNP_MSB:`OFR_RSP_ANY]);
  // latency needs the second counter counting the same requests
  assign pairBad = lat0 && ctrl_q[0] &&
                   (!ctrl_q[1] || filt0_q[15:0] != filt1_q[15:0] ||
                    filt0_q[49:44] != filt1_q[49:44]);

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  assign sum0 = {1'b0, cnt0_q} + {{(33-CW){1'b0}}, inc0_q};
  assign sum1 = {1'b0, cnt1_q} + {{(33-CW){1'b0}}, inc1_q};
  assign countInc0 = inc0_q;
  assign countInc1 = inc1_q;
  assign protectionFault = fault_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      inc0_q <= {CW{1'b0}};
      inc1_q <= {CW{1'b0}};
      cnt0_q <= 32'h00000000;
      cnt1_q <= 32'h00000000;
    end else if (ce) begin
      // an incomplete filter counts nothing
      inc0_q <= (ctrl_q[0] && cfgOk0 && !latBad) ? inc0 : {CW{1'b0}};
      inc1_q <= (ctrl_q[1] && cfgOk1) ? inc1 : {CW{1'b0}};
      if (doWrite && awAddr_q == `OFR_ADDR_CNT0) begin
        cnt0_q <= merge(cnt0_q, wData_q, wStrb_q);
      end else begin
        cnt0_q <= sum0[31:0];
      end
      if (doWrite && awAddr_q == `OFR_ADDR_CNT1) begin
        cnt1_q <= merge(cnt1_q, wData_q, wStrb_q);
      end else begin
        cnt1_q <= sum1[31:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // status and interrupt
  // ---------------------------------------------------------------
  assign stSet = {pairBad, sum1[32], sum0[32],
                  ctrl_q[1] && !cfgOk1, ctrl_q[0] && (!cfgOk0 || latBad),
                  doWrite && badHi1};
  assign stClr = (doWrite && awAddr_q == `OFR_ADDR_STAT && wStrb_q[0]) ?
                 wData_q[`OFR_ST_W-1:0] : {`OFR_ST_W{1'b0}};
  assign irq = |(status_q & mask_q);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= {`OFR_ST_W{1'b0}};
    end else if (ce) begin
      // a new event beats a clear in the same cycle
      status_q <= (status_q & ~stClr) | stSet;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= `OFR_RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && !rValid_q) begin
        rValid_q <= 1'b1;
        rResp_q <= known(s_axi_araddr) ? `OFR_RESP_OK : `OFR_RESP_DECERR;
        case (s_axi_araddr)
          `OFR_ADDR_F0_LO: rData_q <= filt0_q[31:0];
          `OFR_ADDR_F0_HI: rData_q <= filt0_q[63:32];
          `OFR_ADDR_F1_LO: rData_q <= filt1_q[31:0];
          `OFR_ADDR_F1_HI: rData_q <= filt1_q[63:32];
          `OFR_ADDR_STAT: rData_q <= {{(32-`OFR_ST_W){1'b0}}, status_q};
          `OFR_ADDR_MASK: rData_q <= {{(32-`OFR_ST_W){1'b0}}, mask_q};
          `OFR_ADDR_CTRL: rData_q <= {30'h00000000, ctrl_q};
          `OFR_ADDR_CNT0: rData_q <= cnt0_q;
          `OFR_ADDR_CNT1: rData_q <= cnt1_q;
          `OFR_ADDR_CFG: rData_q <= {27'h0000000, latBad, lat1, lat0, cfgOk1, cfgOk0};
          default: rData_q <= 32'h00000000;
        endcase
      end else if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end
  end
endmodule // ofr_filter_top

// ===== ofr_filter_top_chk.sv
/*
  Checker for the off-core response filter: bus timing, refusal of the
  latency bit in the second filter, fault pulse and clock-enable freeze.
  Assumes it is bound into ofr_filter_top and sees only its ports.
*/
`include "ofr_consts.vh"

module ofr_filter_top_chk (
  input wire clk, // core clock
  input wire reset, // async reset
  input wire ce, // clock enable
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // strobes
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire [1:0] s_axi_bresp, // write answer
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // read data
  input wire [1:0] s_axi_rresp, // read answer
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire protectionFault, // fault pulse
  input wire irq // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  // latency bit written as one into the second filter
  sequence faultWr;
    wrBoth ##0 (s_axi_awaddr == `OFR_ADDR_F1_HI && s_axi_wstrb[3] && s_axi_wdata[31]);
  endsequence
  sequence faultAns;
    s_axi_bvalid && s_axi_bresp == `OFR_RESP_SLVERR ##[0:1] protectionFault;
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_WR_ANSWER: assert property (wrBoth |=> ##1 s_axi_bvalid)
    else $error("write answer missing");
  AST_RD_ANSWER: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RD_HOLD: assert property (s_axi_rvalid && !(s_axi_rready && ce) |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  AST_WR_HOLD: assert property (s_axi_bvalid && !(s_axi_bready && ce) |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_READY_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_FAULT_WR: assert property (faultWr |=> ##1 faultAns)
    else $error("latency bit write to second filter not refused");
  AST_FAULT_PULSE: assert property (protectionFault && ce |=> !protectionFault)
    else $error("fault longer than one cycle");
  AST_DECERR: assert property (rdTaken ##0 (s_axi_araddr > 8'h24) |=>
    s_axi_rresp == `OFR_RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  AST_FREEZE: assert property (!ce |=>
    $stable(s_axi_bvalid) && $stable(s_axi_rvalid) && $stable(irq))
    else $error("state moved with enable low");
endmodule // ofr_filter_top_chk

bind ofr_filter_top ofr_filter_top_chk ofr_filter_top_chk_inst (.clk, .reset, .ce,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .protectionFault, .irq);

// ===== ofr_filter_top_tb.sv
/*
  Self-checking bench for the off-core response filter: registers over
  AXI4-Lite, fault and interrupt, and random transactions per programming.
  Assumes the design files and ofr_consts.vh are compiled alongside.
*/
`include "ofr_consts.vh"

module ofr_filter_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, ce = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire protectionFault, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic txnValid = 0, txnIsPrefetch = 0, txnIsWrite = 0, txnAnyRsp = 0, txnSeen = 0;
  logic [5:0] txnReqIdx = 0, k;
  logic [13:0] txnSupplier = 0, sp;
  logic [6:0] txnProbe = 0, pb;
  logic [7:0] outstandingCnt = 0, e0, e1, s0, s1;
  wire [7:0] countInc0, countInc1;
  logic [31:0] seed = 32'ha08b83ef, r;
  logic [63:0] f0, f1;
  logic [1:0] bQ[$];
  logic [33:0] rQ[$];
  logic [15:0] iQ[$];
  int failures = 0, checked = 0, cycles = 0, faults = 0;
  logic [5:0] legal [17] = '{0, 1, 2, 3, 4, 5, 6, 10, 11, 12, 15, 44, 45, 46, 47, 48, 49};
  // any-response, supplier and probe, writebacks, reserved only, kinds, latency, no outcome
  logic [63:0] prog [7] = '{64'h0000000000050001, 64'h0000001084040006,
    64'h0003200200200800, 64'h0000000000010080, 64'h0000d00000018001,
    64'h8000000000000001, 64'h0000000000000001};

  ofr_filter_top #(.CW(8)) ofr_filter_top_inst (.clk, .reset, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txnValid,
    .txnReqIdx, .txnIsPrefetch, .txnIsWrite, .txnSupplier, .txnAnyRsp, .txnProbe,
    .outstandingCnt, .countInc0, .countInc1, .protectionFault, .irq);

  always #2 clk = ~clk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task final_report;
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  function automatic okCfg(input [63:0] f);
    okCfg = (|(f[15:0] & 16'h9c7f) || |f[49:44]) &&
      (f[16] || (|f[30:17] && |f[37:31]) || f[63]);
  endfunction

  function automatic [7:0] expInc(input [63:0] f, input [5:0] i, input pf, input wr,
    input [13:0] su, input an, input [6:0] pr, input [7:0] oc);
    logic [5:0] q;
    logic rsp;
    q = (i == 6'd0 && pf) ? 6'd10 : i;
    rsp = f[16] ? an : (|(su & f[30:17]) && (wr || |(pr & f[37:31])));
    if (!okCfg(f))
      expInc = 8'h0;
    else if (f[63])
      expInc = oc;
    else
      expInc = {7'h0, f[q] && rsp};
  endfunction

  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
    logic a1 = 0, w1 = 0;
    @(posedge clk);
    bQ.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(a1 && w1)) begin
      @(posedge clk);
      if (!a1 && s_axi_awready) begin
        a1 = 1;
        s_axi_awvalid <= 0;
      end
      if (!w1 && s_axi_wready) begin
        w1 = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1;
    @(posedge clk);
    s_axi_bready <= 0;
  endtask

  task automatic rd(input [7:0] a, input [33:0] e);
    @(posedge clk);
    rQ.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    while (!s_axi_rvalid) @(posedge clk);
    // ready raised late so the answer has to stand
    s_axi_rready <= 1;
    @(posedge clk);
    s_axi_rready <= 0;
  endtask

  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report;
    end
    if (!reset && protectionFault)
      faults++;
    if (!reset && s_axi_bvalid && s_axi_bready)
      cmp({32'h0, s_axi_bresp}, {32'h0, bQ.pop_front()}, "write answer");
    if (!reset && s_axi_rvalid && s_axi_rready)
      cmp({s_axi_rresp, s_axi_rdata}, rQ.pop_front(), "read answer");
    if (txnSeen)
      cmp({18'h0, countInc1, countInc0}, {18'h0, iQ.pop_front()}, "increment");
    txnSeen = txnValid;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    for (int a = 0; a <= 'h24; a += 4)
      rd(a[7:0], 34'h0);
    rd(8'h28, {`OFR_RESP_DECERR, 32'h0});
    wr(8'h2c, 32'hffffffff, 4'hf, `OFR_RESP_DECERR);
    wr(`OFR_ADDR_F0_LO, 32'h12345678, 4'h5, `OFR_RESP_OK);
    rd(`OFR_ADDR_F0_LO, {2'h0, 32'h00340078});
    wr(`OFR_ADDR_F1_HI, 32'h80000001, 4'hf, `OFR_RESP_SLVERR);
    rd(`OFR_ADDR_F1_HI, 34'h0);
    rd(`OFR_ADDR_STAT, 34'h1);
    cmp(faults, 1, "fault pulses");
    cmp({33'h0, irq}, 34'h0, "irq masked");
    wr(`OFR_ADDR_MASK, 32'h1, 4'hf, `OFR_RESP_OK);
    repeat (2) @(posedge clk);
    cmp({33'h0, irq}, 34'h1, "irq raised");
    wr(`OFR_ADDR_STAT, 32'h1, 4'hf, `OFR_RESP_OK);
    repeat (2) @(posedge clk);
    cmp({33'h0, irq}, 34'h0, "irq cleared");
    for (int p = 0; p < 7; p++) begin
      f0 = prog[p];
      f1 = prog[(p + 2) % 7] & 64'h7fffffffffffffff;
      wr(`OFR_ADDR_F0_LO, f0[31:0], 4'hf, `OFR_RESP_OK);
      wr(`OFR_ADDR_F0_HI, f0[63:32], 4'hf, `OFR_RESP_OK);
      wr(`OFR_ADDR_F1_LO, f1[31:0], 4'hf, `OFR_RESP_OK);
      wr(`OFR_ADDR_F1_HI, f1[63:32], 4'hf, `OFR_RESP_OK);
      wr(`OFR_ADDR_CNT0, 32'h0, 4'hf, `OFR_RESP_OK);
      wr(`OFR_ADDR_CNT1, 32'h0, 4'hf, `OFR_RESP_OK);
      wr(`OFR_ADDR_CTRL, 32'h3, 4'hf, `OFR_RESP_OK);
      rd(`OFR_ADDR_CFG, {31'h0, f0[63], okCfg(f1), okCfg(f0)});
      s0 = 0;
      s1 = 0;
      for (int n = 0; n < 40; n++) begin
        @(posedge clk);
        seed = lfsr(seed);
        r = lfsr(seed);
        k = legal[seed[4:0] % 17];
        sp = seed[21:8] & r[13:0];
        pb = r[20:14] & r[27:21];
        e0 = expInc(f0, k, seed[5], seed[6], sp, seed[7], pb, r[31:24]);
        e1 = expInc(f1, k, seed[5], seed[6], sp, seed[7], pb, r[31:24]);
        iQ.push_back({e1, e0});
        s0 += e0;
        s1 += e1;
        txnValid <= 1;
        txnReqIdx <= k;
        txnIsPrefetch <= seed[5];
        txnIsWrite <= seed[6];
        txnAnyRsp <= seed[7];
        txnSupplier <= sp;
        txnProbe <= pb;
        outstandingCnt <= r[31:24];
      end
      @(posedge clk);
      txnValid <= 0;
      repeat (3) @(posedge clk);
      // latency mode keeps adding every cycle, so its total is not tracked
      if (!f0[63])
        rd(`OFR_ADDR_CNT0, {26'h0, s0});
      rd(`OFR_ADDR_CNT1, {26'h0, s1});
    end
    @(posedge clk);
    ce <= 0;
    repeat (3) @(posedge clk);
    ce <= 1;
    repeat (2) @(posedge clk);
    cmp(faults, 1, "no further fault");
    final_report;
  end
endmodule // ofr_filter_top_tb
